// ===== hw/fsm_flash_host.sv
// host controller driving the pins of a parallel boot-sector flash
// assumes one 250 MHz clock; only the ready/busy pin enters via a three-stage synchroniser, data pins are sampled directly
`timescale 1ns/100ps
module fsm_flash_host
    import fsm_pkg::*;
#(
    parameter int unsigned reset_cycles = fsm_reset_cycles
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic cfg_top_boot,
    input wire logic cfg_word_mode,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_ident,
    input wire logic req_hw_reset,
    input wire logic req_soft_reset,
    input wire logic [18:0] req_addr,
    input wire logic [15:0] req_wdata,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic [3:0] rsp_sector,
    output fsm_read_mode_type rsp_mode,
    output logic [17:0] flash_addr,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_reset_n,
    output logic flash_byte_n,
    input wire logic [15:0] flash_dq_in,
    output logic [15:0] flash_dq_out,
    output logic [15:0] flash_dq_oe,
    input wire logic flash_ready_in
);
    typedef enum logic [2:0] {
        fsm_idle,
        fsm_setup,
        fsm_strobe,
        fsm_hold,
        fsm_reset_pulse,
        fsm_recover
    } fsm_state_type;

    fsm_state_type state_reg;
    logic [31:0] count_reg;
    logic op_write_reg;
    logic [18:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [3:0] sector_reg;
    logic [15:0] rdata_reg;
    logic rsp_valid_reg;
    logic [2:0] ready_sync_reg;
    logic ready_reg;
    fsm_read_mode_type mode_reg;
    logic [3:0] sector_next;
    logic dq_drive;
    logic [18:0] decode_addr;

    // ****************************************
    // ready/busy pin synchroniser
    // ****************************************
    // change accepted once stages two and three agree
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ready_sync_reg <= 3'h7;
            ready_reg <= 1'b1;
        end else begin
            ready_sync_reg <= {ready_sync_reg[1:0], flash_ready_in};
            if (ready_sync_reg[1] == ready_sync_reg[2]) begin
                ready_reg <= ready_sync_reg[2];
            end
        end
    end

    // word requests carry a word address; the decoder always wants the byte address
    assign decode_addr = cfg_word_mode ? {req_addr[17:0], 1'b0} : req_addr;

    fsm_sector_decode u_decode (
        .top_boot(cfg_top_boot),
        .addr(decode_addr),
        .sector(sector_next)
    );

    assign req_ready = (state_reg == fsm_idle);

    // ****************************************
    // bus cycle sequencer
    // ****************************************
    // address and data stable across the whole strobe so the device latches cleanly
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg <= fsm_reset_pulse; // device starts from a clean hardware reset
            count_reg <= 32'h0;
            op_write_reg <= 1'b0;
            addr_reg <= 19'h0;
            wdata_reg <= 16'h0;
            sector_reg <= 4'h0;
        end else begin
            case (state_reg)
                fsm_idle: begin
                    count_reg <= 32'h0;
                    if (req_valid) begin
                        addr_reg <= req_addr;
                        sector_reg <= sector_next;
                        if (req_hw_reset) begin
                            state_reg <= fsm_reset_pulse;
                        end else begin
                            op_write_reg <= req_write | req_soft_reset | req_ident;
                            wdata_reg <= req_soft_reset ? fsm_soft_reset_data : req_wdata;
                            state_reg <= fsm_setup;
                        end
                    end
                end
                fsm_setup: begin
                    if (count_reg >= 32'(fsm_setup_cycles - 1)) begin
                        count_reg <= 32'h0;
                        state_reg <= fsm_strobe;
                    end else begin
                        count_reg <= count_reg + 32'h1;
                    end
                end
                fsm_strobe: begin
                    if (count_reg >= 32'(op_write_reg ? fsm_strobe_cycles - 1 : fsm_access_cycles - 1)) begin
                        count_reg <= 32'h0;
                        state_reg <= fsm_hold;
                    end else begin
                        count_reg <= count_reg + 32'h1;
                    end
                end
                fsm_hold: begin
                    state_reg <= fsm_idle;
                end
                fsm_reset_pulse: begin
                    if (count_reg >= 32'(reset_cycles - 1)) begin
                        count_reg <= 32'h0;
                        state_reg <= fsm_recover;
                    end else begin
                        count_reg <= count_reg + 32'h1;
                    end
                end
                fsm_recover: begin
                    // wait for ready as well, in case reset hit a running algorithm
                    if (count_reg >= 32'(fsm_recover_cycles - 1) && ready_reg) begin
                        count_reg <= 32'h0;
                        state_reg <= fsm_idle;
                    end else if (count_reg < 32'(fsm_recover_cycles - 1)) begin
                        count_reg <= count_reg + 32'h1;
                    end
                end
                default: begin
                    state_reg <= fsm_idle;
                end
            endcase
        end
    end

    // ****************************************
    // read capture
    // ****************************************
    // sample at end of access time, before the strobe releases
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata_reg <= 16'h0;
            rsp_valid_reg <= 1'b0;
        end else begin
            rsp_valid_reg <= 1'b0;
            if (state_reg == fsm_strobe && !op_write_reg
                && count_reg >= 32'(fsm_access_cycles - 1)) begin
                rsp_valid_reg <= 1'b1;
                // byte mode: only the low lane carries data
                rdata_reg <= cfg_word_mode ? flash_dq_in : (flash_dq_in & {8'h0, fsm_byte_mask});
            end
        end
    end

    // ****************************************
    // tracked device read mode
    // ****************************************
    // busy pin means status reads; only resets leave identification
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode_reg <= fsm_read_array;
        end else if (state_reg == fsm_reset_pulse) begin
            mode_reg <= fsm_read_array;
        end else if (state_reg == fsm_idle && req_valid && req_soft_reset) begin
            mode_reg <= fsm_read_array;
        end else if (state_reg == fsm_idle && req_valid && req_ident) begin
            mode_reg <= fsm_read_ident;
        end else if (mode_reg != fsm_read_ident && !ready_reg) begin
            mode_reg <= fsm_read_status;
        end else if (mode_reg == fsm_read_status && ready_reg) begin
            mode_reg <= fsm_read_array;
        end
    end

    // ****************************************
    // pin drive
    // ****************************************
    assign dq_drive = op_write_reg && (state_reg == fsm_setup || state_reg == fsm_strobe
        || state_reg == fsm_hold);

    always_comb begin
        flash_reset_n = (state_reg != fsm_reset_pulse);
        flash_byte_n = cfg_word_mode;
        flash_ce_n = !(state_reg == fsm_setup || state_reg == fsm_strobe || state_reg == fsm_hold);
        // read: oe low we high; write: we low oe high
        flash_oe_n = !((state_reg == fsm_strobe || state_reg == fsm_hold) && !op_write_reg);
        flash_we_n = !(state_reg == fsm_strobe && op_write_reg);
        flash_addr = cfg_word_mode ? addr_reg[17:0] : addr_reg[18:1];
        flash_dq_out = cfg_word_mode ? wdata_reg : {addr_reg[0], 7'h0, wdata_reg[7:0]};
        if (cfg_word_mode) begin
            flash_dq_oe = {16{dq_drive}};
        end else begin
            // top pin driven as address lsb in every state but idle and reset pulse, 14..8 left floating
            flash_dq_oe = {(state_reg != fsm_idle && state_reg != fsm_reset_pulse), 7'h0, {8{dq_drive}}};
        end
    end

    assign rsp_valid = rsp_valid_reg;
    assign rsp_rdata = rdata_reg;
    assign rsp_sector = sector_reg;
    assign rsp_mode = mode_reg;
endmodule

// ===== hw/fsm_pkg.sv
// constants for the host-side controller of a parallel boot-sector flash
// assumes the flash pins are wired straight to the controller ports
package fsm_pkg;
    // ****************************************
    // array geometry
    // ****************************************
    localparam int unsigned fsm_word_addr_width = 18;
    localparam int unsigned fsm_byte_addr_width = 19;
    localparam int unsigned fsm_data_width = 16;
    localparam int unsigned fsm_sector_count = 11;
    localparam logic [3:0] fsm_last_sector = 4'ha;
    localparam logic [18:0] fsm_top_s7_base = 19'h70000;
    localparam logic [18:0] fsm_top_s8_base = 19'h78000;
    localparam logic [18:0] fsm_top_s9_base = 19'h7a000;
    localparam logic [18:0] fsm_top_s10_base = 19'h7c000;
    localparam logic [18:0] fsm_bot_s1_base = 19'h04000;
    localparam logic [18:0] fsm_bot_s2_base = 19'h06000;
    localparam logic [18:0] fsm_bot_s3_base = 19'h08000;
    localparam logic [18:0] fsm_big_sector_base = 19'h10000;
    localparam int unsigned fsm_big_sector_shift = 16;
    localparam logic [3:0] fsm_bot_big_first = 4'h3;
    localparam logic [7:0] fsm_byte_mask = 8'hff;
    // ****************************************
    // bus timing
    // ****************************************
    localparam int unsigned fsm_clock_mhz = 250;
    localparam int unsigned fsm_access_ns = 70;
    localparam int unsigned fsm_access_cycles = (fsm_access_ns * fsm_clock_mhz + 999) / 1000;
    localparam int unsigned fsm_strobe_ns = 40;
    localparam int unsigned fsm_strobe_cycles = (fsm_strobe_ns * fsm_clock_mhz + 999) / 1000;
    localparam int unsigned fsm_setup_ns = 8;
    localparam int unsigned fsm_setup_cycles = (fsm_setup_ns * fsm_clock_mhz + 999) / 1000;
    localparam int unsigned fsm_reset_ns = 500;
    localparam int unsigned fsm_reset_cycles = (fsm_reset_ns * fsm_clock_mhz + 999) / 1000;
    localparam int unsigned fsm_recover_ns = 50;
    localparam int unsigned fsm_recover_cycles = (fsm_recover_ns * fsm_clock_mhz + 999) / 1000;
    localparam int unsigned fsm_count_width = 8;
    localparam logic [15:0] fsm_soft_reset_data = 16'h00f0;

    typedef enum logic [1:0] {
        fsm_read_array,
        fsm_read_status,
        fsm_read_ident
    } fsm_read_mode_type;
endpackage

// ===== hw/fsm_sector_decode.sv
// sector number decode for a 19-bit byte address
// assumes addr is always the byte address; word addresses are shifted left by one
`timescale 1ns/100ps
module fsm_sector_decode
    import fsm_pkg::*;
(
    input wire logic top_boot,
    input wire logic [18:0] addr,
    output logic [3:0] sector
);
    // ****************************************
    // decode
    // ****************************************
    // only upper bits count; offsets inside the sector never matter
    always_comb begin
        if (top_boot) begin
            if (addr < fsm_top_s7_base) begin
                sector = {1'b0, addr[18:16]};
            end else if (addr < fsm_top_s8_base) begin
                sector = 4'h7;
            end else if (addr < fsm_top_s9_base) begin
                sector = 4'h8;
            end else if (addr < fsm_top_s10_base) begin
                sector = 4'h9;
            end else begin
                sector = fsm_last_sector;
            end
        end else begin
            if (addr < fsm_bot_s1_base) begin
                sector = 4'h0;
            end else if (addr < fsm_bot_s2_base) begin
                sector = 4'h1;
            end else if (addr < fsm_bot_s3_base) begin
                sector = 4'h2;
            end else if (addr < fsm_big_sector_base) begin
                sector = fsm_bot_big_first;
            end else begin
                sector = fsm_bot_big_first + {1'b0, addr[18:16]};
            end
        end
    end
endmodule

// ===== tb/fsm_flash_host_properties.sv
// concurrent checks on the pins and request port of the flash host controller
// assumes it is bound into fsm_flash_host; one clock domain
`timescale 1ns/100ps
module fsm_flash_host_properties
    import fsm_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire logic req_ident,
    input wire logic req_hw_reset,
    input wire logic req_soft_reset,
    input wire logic rsp_valid,
    input wire logic [3:0] rsp_sector,
    input wire fsm_read_mode_type rsp_mode,
    input wire logic [17:0] flash_addr,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic flash_reset_n,
    input wire logic flash_byte_n,
    input wire logic [15:0] flash_dq_out,
    input wire logic [15:0] flash_dq_oe
);
    // ****************************************
    // pin and request checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // taken requests, split by kind as the priority order sees them
    wire logic taken = req_valid && req_ready;
    wire logic rd = taken && !(req_write || req_ident || req_hw_reset || req_soft_reset);
    a_read_strobes: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n)
        else $error("read strobes wrong");
    a_write_strobes: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
        else $error("write strobes wrong");
    a_byte_float: assert property (!flash_byte_n |-> flash_dq_oe[14:8] == 7'h00)
        else $error("byte mode upper lines driven");
    a_read_no_drive: assert property (!flash_oe_n |-> flash_dq_oe[14:0] == 15'h0000)
        else $error("host drives data during read");
    a_lsb_driven: assert property (!flash_ce_n && !flash_byte_n |-> flash_dq_oe[15])
        else $error("byte address lsb not driven");
    a_addr_held: assert property (!flash_ce_n && $past(!flash_ce_n) |-> $stable(flash_addr))
        else $error("address moved in cycle");
    a_wdata_held: assert property (!flash_we_n && $past(!flash_we_n) |-> $stable(flash_dq_out))
        else $error("write data moved under strobe");
    // setup and access take twenty edges, the capture register adds one
    a_read_answer: assert property (rd |-> ##21 rsp_valid)
        else $error("read answer late or missing");
    a_reset_idle: assert property (!flash_reset_n |-> !req_ready && flash_we_n)
        else $error("activity during flash reset");
    a_ident_mode: assert property (taken && req_ident && !req_hw_reset && !req_soft_reset
        |-> ##[1:40] rsp_mode == fsm_read_ident)
        else $error("identification mode not tracked");
    a_soft_mode: assert property (taken && req_soft_reset && !req_hw_reset
        |-> ##[1:40] rsp_mode == fsm_read_array)
        else $error("soft reset mode not tracked");
    a_sector_range: assert property (rsp_sector <= fsm_last_sector)
        else $error("sector out of range");
endmodule
bind fsm_flash_host fsm_flash_host_properties i_props (.*);

// ===== tb/fsm_flash_host_tb.sv
// self-checking bench for the flash host controller
// assumes fsm_flash_model on the pins and the checker bound to the design
`timescale 1ns/100ps
module fsm_flash_host_tb
    import fsm_pkg::*;
;
    // ****************************************
    // signals, design and flash model
    // ****************************************
    typedef struct packed {logic top; logic wm; logic [18:0] a; logic [3:0] s;} fsm_row_type;
    localparam logic [7:0] id_code = 8'h5e; // arbitrary value
    logic clock = 1'b0, sys_rst = 1'b1, cfg_top_boot = 1'b0, cfg_word_mode = 1'b0, req_valid = 1'b0, busy = 1'b0;
    logic [3:0] kind = 4'h0;
    logic suspend = 1'b0;
    logic [18:0] req_addr = 19'h00000;
    logic [15:0] req_wdata = 16'h0000;
    logic req_ready, rsp_valid, flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n, flash_byte_n, flash_ready_in;
    logic [15:0] rsp_rdata, flash_dq_in, flash_dq_out, flash_dq_oe, last_wdata;
    logic [3:0] rsp_sector;
    logic [17:0] flash_addr;
    fsm_read_mode_type rsp_mode;
    int fail_count = 0;
    int check_count = 0;
    fsm_row_type rows [14] = '{'{1'b1, 1'b0, 19'h70000, 4'h7}, '{1'b1, 1'b0, 19'h78000, 4'h8},
        '{1'b1, 1'b0, 19'h7a001, 4'h9}, '{1'b1, 1'b0, 19'h7c000, 4'ha}, '{1'b1, 1'b0, 19'h6ffff, 4'h6},
        '{1'b1, 1'b1, 19'h12345, 4'h2}, '{1'b0, 1'b1, 19'h2abcd, 4'h8}, '{1'b0, 1'b0, 19'h00000, 4'h0},
        '{1'b0, 1'b0, 19'h03fff, 4'h0}, '{1'b0, 1'b0, 19'h04000, 4'h1}, '{1'b0, 1'b0, 19'h06001, 4'h2},
        '{1'b0, 1'b0, 19'h08000, 4'h3}, '{1'b0, 1'b0, 19'h10000, 4'h4}, '{1'b0, 1'b0, 19'h7ffff, 4'ha}};
    fsm_flash_host #(.reset_cycles(4)) i_fsm_flash_host (.req_write(kind[0]), .req_ident(kind[1]),
        .req_hw_reset(kind[2]), .req_soft_reset(kind[3]), .*);
    fsm_flash_model #(.ident_code(id_code)) i_fsm_flash_model (.*);
    always #2 clock = ~clock;
    // ****************************************
    // tasks
    // ****************************************
    task automatic cmp_data(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_small(input string what, input logic [3:0] exp, input logic [3:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request held from a rising edge until the edge where ready is seen
    task automatic issue(input logic [3:0] k, input logic [18:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clock);
        {req_valid, kind, req_addr, req_wdata} <= {1'b1, k, a, d};
        do begin
            @(negedge clock);
            n++;
        end while (req_ready !== 1'b1 && n < 3000);
        @(posedge clock);
        req_valid <= 1'b0;
    endtask
    task automatic rd_chk(input logic [18:0] a, input logic [15:0] exp, input fsm_read_mode_type m);
        int n;
        n = 0;
        issue(4'h0, a, 16'h0000);
        do begin
            @(negedge clock);
            n++;
        end while (rsp_valid !== 1'b1 && n < 40);
        cmp_small("rsp_valid", 4'h1, {3'h0, rsp_valid});
        cmp_data("rsp_rdata", exp, rsp_rdata);
        cmp_small("rsp_mode", {2'b00, m}, {2'b00, rsp_mode});
    endtask
    // expected array content, byte lane picked by the address lsb
    function automatic logic [15:0] exp_arr(input logic wm, input logic [18:0] a);
        logic [15:0] w;
        w = (wm ? {a[7:0], a[15:8]} : {a[8:1], a[16:9]}) ^ 16'h3c5a;
        return wm ? w : {8'h00, a[0] ? w[15:8] : w[7:0]};
    endfunction
    task automatic print_verdict();
        if (fail_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        rd_chk(19'h00101, exp_arr(1'b0, 19'h00101), fsm_read_array);
        foreach (rows[i]) begin
            @(posedge clock);
            cfg_top_boot <= rows[i].top;
            cfg_word_mode <= rows[i].wm;
            rd_chk(rows[i].a, exp_arr(rows[i].wm, rows[i].a), fsm_read_array);
            cmp_small("rsp_sector", rows[i].s, rsp_sector);
        end
        issue(4'h1, 19'h00456, 16'h00a7);
        issue(4'h8, 19'h00000, 16'h00f0);
        cmp_data("last_wdata", 16'h00a7, {8'h00, last_wdata[7:0]});
        rd_chk(19'h00457, exp_arr(1'b0, 19'h00457), fsm_read_array);
        issue(4'h2, 19'h00010, 16'h0090);
        rd_chk(19'h00200, {8'h00, id_code}, fsm_read_ident);
        rd_chk(19'h7ffff, {8'h00, id_code}, fsm_read_ident);
        issue(4'h4, 19'h00000, 16'h0000);
        rd_chk(19'h00203, exp_arr(1'b0, 19'h00203), fsm_read_array);
        busy <= 1'b1;
        repeat (8) @(posedge clock);
        rd_chk(19'h00300, 16'h00c4, fsm_read_status);
        busy <= 1'b0;
        repeat (8) @(posedge clock);
        rd_chk(19'h00301, exp_arr(1'b0, 19'h00301), fsm_read_array);
        // host only sees the busy pin, so its tracked mode stays array here
        suspend <= 1'b1;
        rd_chk(19'h00302, exp_arr(1'b0, 19'h00302), fsm_read_array);
        rd_chk(19'h70001, 16'h00c4, fsm_read_array);
        print_verdict();
    end
endmodule

// ===== tb/fsm_flash_model.sv
// behavioural model of the parallel flash on the controller's far side
// assumes the controller pins directly; busy is commanded by the bench
`timescale 1ns/100ps
module fsm_flash_model
#(
    parameter logic [7:0] ident_code = 8'h5e, // arbitrary value
    parameter logic [15:0] status_value = 16'h00c4
)
(
    input wire logic [17:0] flash_addr,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic flash_reset_n,
    input wire logic flash_byte_n,
    input wire logic [15:0] flash_dq_out,
    input wire logic [15:0] flash_dq_oe,
    input wire logic busy,
    input wire logic suspend,
    output logic [15:0] flash_dq_in,
    output logic flash_ready_in,
    output logic [15:0] last_wdata
);
    // ****************************************
    // command latch and read path
    // ****************************************
    logic ident_reg = 1'b0;
    logic [15:0] word;
    logic [15:0] rd;
    logic drive;
    logic lsb_pin;
    // command latch sits apart from the array; data taken as the strobe rises
    always @(posedge flash_we_n or negedge flash_reset_n) begin
        if (!flash_reset_n) begin
            ident_reg <= 1'b0;
        end else if (!flash_ce_n) begin
            last_wdata <= flash_dq_out;
            ident_reg <= (flash_dq_out[7:0] != 8'hf0);
        end
    end
    // array content is a fixed scramble of the word address
    assign word = {flash_addr[7:0], flash_addr[15:8]} ^ 16'h3c5a;
    // byte lsb is what the pin shows, so an undriven pin reads as the inverse
    assign lsb_pin = flash_dq_out[15] ~^ flash_dq_oe[15];
    // suspended erase covers the top 64 KB region; other sectors still read as array
    always_comb begin
        rd = ident_reg ? {8'h00, ident_code} : word;
        if (!flash_byte_n && lsb_pin && !ident_reg) rd = {8'h00, word[15:8]};
        if (busy || (suspend && flash_addr[17:15] == 3'b111)) rd = status_value;
    end
    assign drive = !flash_ce_n && !flash_oe_n && flash_we_n && flash_reset_n;
    // released lines show the inverse of the host value, never a stale copy
    always_comb begin
        flash_dq_in = flash_dq_out ~^ flash_dq_oe;
        if (drive) flash_dq_in[7:0] = rd[7:0];
        if (drive && flash_byte_n) flash_dq_in[15:8] = rd[15:8];
    end
    assign flash_ready_in = !busy;
endmodule
